// ### include/lcg_pkg.sv
// package: register map, field layout and constants of the gate input select stage
// Notes on behaviour
// - The gate 3/4 enable register is 16 bits, gate 4 in bits 15:8 and gate 3 in bits 7:0, all read/write.
// - A set true-form enable passes its data source unchanged into its gate, a clear one keeps it out.
// - A set negated-form enable passes the inverse of its data source into its gate, a clear one keeps it out.
// - Within a gate byte the enables run from source 4 down to source 1, true bit above negated bit, gate 4 source 4 true at bit 15.
// - Gate 3 uses the same order in the low byte, source 4 true at bit 7 and source 1 negated at bit 0.
// - In the gate 1/2 enable register gate 1 fills bits 7:0 in the same order, source 4 true at bit 7.
// - In the gate 1/2 enable register gate 2 source 1 true sits at bit 9 and source 1 negated at bit 8.
// - The gate 1/2 enable register is a 16-bit register at its own offset just below the gate 3/4 register.
// - Each gate output passes a per-gate polarity control that inverts it when set.
// - Each of the four data sources is chosen by its own 3-bit select field among pins, peripheral outputs and clocks.
package lcg_pkg;
  localparam int unsigned      NUM_GATES    = 4;
  localparam int unsigned      NUM_SOURCES  = 4;
  localparam int unsigned      SEL_W        = 3;
  localparam int unsigned      SEL_INPUTS   = 8;
  localparam int unsigned      REG_W        = 16;
  localparam int unsigned      GATE_BITS    = 8;
  localparam int unsigned      ADDR_W       = 14;
  localparam logic [11:0]      OFF_POLARITY = 12'h48a;
  localparam logic [11:0]      OFF_SELECT   = 12'h48c;
  localparam logic [11:0]      OFF_GATE12   = 12'h490;
  localparam logic [11:0]      OFF_GATE34   = 12'h492;
  // offsets are register indices; the bus byte address is four times the index
  localparam logic [ADDR_W-1:0] ADDR_POLARITY = {OFF_POLARITY, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SELECT   = {OFF_SELECT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GATE12   = {OFF_GATE12, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GATE34   = {OFF_GATE34, 2'b00};
  localparam logic [15:0]      RST_ENABLES  = 16'h0000;
  localparam logic [15:0]      RST_SELECT   = 16'h0000;
  localparam logic [3:0]       RST_POLARITY = 4'h0;
  localparam int unsigned      SEL_STRIDE   = 4;
  localparam logic [1:0]       RESP_OKAY    = 2'b00;
  localparam logic [1:0]       RESP_SLVERR  = 2'b10;
endpackage

// ### include/lcg_cfg_if.sv
// interface: configuration carried from the register file to the gate stage
`timescale 1ns/10ps
interface lcg_cfg_if;
  import lcg_pkg::*;
  logic [REG_W-1:0] gate12_input_enables;
  logic [REG_W-1:0] gate34_input_enables;
  logic [REG_W-1:0] source_select;
  logic [3:0]       gate_polarity;
  modport regs (output gate12_input_enables, output gate34_input_enables,
                output source_select, output gate_polarity);
  modport gates (input gate12_input_enables, input gate34_input_enables,
                 input source_select, input gate_polarity);
endinterface

// ### logic/lcg_gate_stage.sv
// gate stage: source muxes, true/negated enables, or gates and polarity
`timescale 1ns/10ps
module lcg_gate_stage
  import lcg_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clk_en,
  lcg_cfg_if.gates                   cfg,
  input  wire logic [SEL_INPUTS-1:0] src_in [NUM_SOURCES],
  output logic      [NUM_SOURCES-1:0] source_data,
  output logic      [NUM_GATES-1:0]  gate_out
);
  logic [2*REG_W-1:0]     all_en;
  logic [NUM_GATES-1:0]   next_gate_out;
  logic [NUM_SOURCES-1:0] ds;

  assign all_en = {cfg.gate34_input_enables, cfg.gate12_input_enables};

  genvar s;
  generate
    for (s = 0; s < NUM_SOURCES; s++) begin : g_src
      assign ds[s] = src_in[s][cfg.source_select[s*SEL_STRIDE +: SEL_W]];
    end
  endgenerate

  always_comb begin
    logic                 acc;
    logic [GATE_BITS-1:0] gb;
    acc           = 1'b0;
    gb            = '0;
    next_gate_out = '0;
    for (int g = 0; g < NUM_GATES; g++) begin
      acc = 1'b0;
      gb  = all_en[g*GATE_BITS +: GATE_BITS];
      for (int k = 0; k < NUM_SOURCES; k++) begin
        // source k: true at bit 2k+1, negated at bit 2k
        acc = acc | (gb[2*k+1] & ds[k]);
        acc = acc | (gb[2*k] & ~ds[k]);
      end
      next_gate_out[g] = acc ^ cfg.gate_polarity[g];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_out    <= '0;
      source_data <= '0;
    end else if (clk_en) begin
      gate_out    <= next_gate_out;
      source_data <= ds;
    end
  end

  AST_POLARITY_INVERT: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && all_en[GATE_BITS-1:0] == '0 |=> gate_out[0] == $past(cfg.gate_polarity[0]))
    else $error("gate 1 with no inputs does not follow polarity");
  AST_TRUE_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && all_en[15:8] == 8'h02 && !cfg.gate_polarity[1] |=> gate_out[1] == $past(ds[0]))
    else $error("gate 2 true source 1 not passed");
  AST_NEG_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && all_en[31:24] == 8'h40 && !cfg.gate_polarity[3] |=> gate_out[3] == !$past(ds[3]))
    else $error("gate 4 negated source 4 not passed");
  AST_GATE3_ORDER: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && all_en[23:16] == 8'h81 && !cfg.gate_polarity[2]
      |=> gate_out[2] == ($past(ds[3]) | !$past(ds[0])))
    else $error("gate 3 bit order wrong");
  AST_GATE4_TOP: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && all_en[31:24] == 8'h80 && !cfg.gate_polarity[3] |=> gate_out[3] == $past(ds[3]))
    else $error("gate 4 source 4 true not at top bit");
  AST_GATE1_TOP: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && all_en[7:0] == 8'h80 && !cfg.gate_polarity[0] |=> gate_out[0] == $past(ds[3]))
    else $error("gate 1 source 4 true not at bit 7");
  AST_GATE2_NEG1: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && all_en[15:8] == 8'h01 && !cfg.gate_polarity[1] |=> gate_out[1] == !$past(ds[0]))
    else $error("gate 2 source 1 negated not at bit 8");
  AST_SOURCE_MUX: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> source_data[1] == $past(src_in[1][cfg.source_select[6:4]]))
    else $error("source 2 select wrong");
  AST_OR_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && all_en[23:16] == '0 && !cfg.gate_polarity[2] |=> !gate_out[2])
    else $error("gate 3 not zero with no input");
endmodule

// ### logic/lcg_gate_select.sv
// top: axi4-lite register file and gate input selection stage
`timescale 1ns/10ps
module lcg_gate_select
  import lcg_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clk_en,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [SEL_INPUTS-1:0] src_in [NUM_SOURCES],
  output logic [NUM_SOURCES-1:0]     source_data,
  output logic [NUM_GATES-1:0]       gate_out
);
  lcg_cfg_if cfg ();

  logic [REG_W-1:0] gate12_input_enables, next_gate12;
  logic [REG_W-1:0] gate34_input_enables, next_gate34;
  logic [REG_W-1:0] source_select, next_select;
  logic [3:0]       gate_polarity, next_polarity;
  logic             aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0]      w_data, next_w_data;
  logic [3:0]       w_strb, next_w_strb;
  logic             next_bvalid, next_rvalid;
  logic [1:0]       next_bresp, next_rresp;
  logic [31:0]      next_rdata;
  logic             do_write;
  logic [REG_W-1:0] wmask;

  assign cfg.gate12_input_enables = gate12_input_enables;
  assign cfg.gate34_input_enables = gate34_input_enables;
  assign cfg.source_select        = source_select;
  assign cfg.gate_polarity        = gate_polarity;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wmask = {{GATE_BITS{w_strb[1]}}, {GATE_BITS{w_strb[0]}}};
  assign do_write = aw_held && w_held;

  always_comb begin
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    next_gate12   = gate12_input_enables;
    next_gate34   = gate34_input_enables;
    next_select   = source_select;
    next_polarity = gate_polarity;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (aw_addr == ADDR_GATE12) begin
        next_gate12 = (gate12_input_enables & ~wmask) | (w_data[15:0] & wmask);
      end else if (aw_addr == ADDR_GATE34) begin
        next_gate34 = (gate34_input_enables & ~wmask) | (w_data[15:0] & wmask);
      end else if (aw_addr == ADDR_SELECT) begin
        next_select = (source_select & ~wmask) | (w_data[15:0] & wmask);
      end else if (aw_addr == ADDR_POLARITY) begin
        if (w_strb[0]) begin
          next_polarity = w_data[3:0];
        end
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;
      if (s_axi_araddr == ADDR_GATE12) begin
        next_rdata[15:0] = gate12_input_enables;
      end else if (s_axi_araddr == ADDR_GATE34) begin
        next_rdata[15:0] = gate34_input_enables;
      end else if (s_axi_araddr == ADDR_SELECT) begin
        next_rdata[15:0] = source_select;
      end else if (s_axi_araddr == ADDR_POLARITY) begin
        next_rdata[3:0] = gate_polarity;
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate12_input_enables <= RST_ENABLES;
      gate34_input_enables <= RST_ENABLES;
      source_select        <= RST_SELECT;
      gate_polarity        <= RST_POLARITY;
      aw_held              <= 1'b0;
      w_held               <= 1'b0;
      aw_addr              <= '0;
      w_data               <= '0;
      w_strb               <= '0;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= RESP_OKAY;
      s_axi_rvalid         <= 1'b0;
      s_axi_rdata          <= '0;
      s_axi_rresp          <= RESP_OKAY;
    end else if (clk_en) begin
      gate12_input_enables <= next_gate12;
      gate34_input_enables <= next_gate34;
      source_select        <= next_select;
      gate_polarity        <= next_polarity;
      aw_held              <= next_aw_held;
      w_held               <= next_w_held;
      aw_addr              <= next_aw_addr;
      w_data               <= next_w_data;
      w_strb               <= next_w_strb;
      s_axi_bvalid         <= next_bvalid;
      s_axi_bresp          <= next_bresp;
      s_axi_rvalid         <= next_rvalid;
      s_axi_rdata          <= next_rdata;
      s_axi_rresp          <= next_rresp;
    end
  end

  lcg_gate_stage u_stage (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .clk_en      (clk_en),
    .cfg         (cfg.gates),
    .src_in      (src_in),
    .source_data (source_data),
    .gate_out    (gate_out)
  );

  AST_GATE34_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && do_write && aw_addr == ADDR_GATE34 && w_strb[1:0] == 2'b11
      |=> gate34_input_enables == $past(w_data[15:0]))
    else $error("gate 3/4 register write lost");
  AST_GATE12_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && do_write && aw_addr == ADDR_GATE12 && w_strb[1:0] == 2'b11
      |=> gate12_input_enables == $past(w_data[15:0]))
    else $error("gate 1/2 register write lost");
  AST_READ_BACK: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_GATE34
      |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(gate34_input_enables)})
    else $error("gate 3/4 readback wrong");
endmodule

// ### test/lcg_gate_select_tb_top.sv
// testbench: register access and gate input selection checks over axi4-lite
`timescale 1ns/10ps
module lcg_gate_select_tb_top;
  import lcg_pkg::*;
  logic                  aclk, aresetn, clk_en;
  logic [ADDR_W-1:0]     s_axi_awaddr, s_axi_araddr;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  logic [31:0]           s_axi_wdata, s_axi_rdata, d;
  logic [3:0]            s_axi_wstrb, gate_out, source_data, e;
  logic [1:0]            s_axi_bresp, s_axi_rresp, r;
  logic [SEL_INPUTS-1:0] src_in [NUM_SOURCES];
  logic [ADDR_W-1:0]     offs [4];
  int                    num_errors, comparisons, g, b, p, i, k;

  lcg_gate_select u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .src_in(src_in), .source_data(source_data),
    .gate_out(gate_out));

  always #2 aclk = ~aclk;

  task automatic close_out();
    $display("TB: %0d comparisons, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    chk_reg({30'h0, got}, {30'h0, exp}, what);
  endtask

  task automatic chk_sig(input logic [3:0] got, input logic [3:0] exp, input string what);
    chk_reg({28'h0, got}, {28'h0, exp}, what);
  endtask

  // raise after a rising edge, sample each handshake at the edge that takes it
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                           input logic [3:0] st, output logic [1:0] rsp);
    logic busy;
    busy = 1'b1;
    rsp  = RESP_SLVERR;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 100 && busy; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        busy = 1'b0;
      end
    end
    if (busy) begin
      num_errors++;
      $display("ERROR %0t: write response timeout", $time);
      close_out();
    end
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] rd,
                          output logic [1:0] rsp);
    logic busy;
    busy = 1'b1;
    rd   = '0;
    rsp  = RESP_SLVERR;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 100 && busy; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rd  = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        busy = 1'b0;
      end
    end
    if (busy) begin
      num_errors++;
      $display("ERROR %0t: read data timeout", $time);
      close_out();
    end
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0]  rsp;
    axi_read(a, rd, rsp);
    chk_reg(rd, exp, "read data");
    chk_resp(rsp, er, "read response");
  endtask

  initial begin
    aclk = 0; aresetn = 0; clk_en = 1; s_axi_awaddr = 0; s_axi_araddr = 0;
    s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0; s_axi_arvalid = 0;
    s_axi_rready = 0; s_axi_wdata = 0; s_axi_wstrb = 0;
    for (i = 0; i < 4; i++) src_in[i] = 8'h00;
    offs = '{ADDR_GATE12, ADDR_GATE34, ADDR_SELECT, ADDR_POLARITY};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 4; i++) rd_chk(offs[i], 32'h0, RESP_OKAY);
    $display("TB: reset values done");
    axi_write(ADDR_GATE34, 32'hffffa5c3, 4'hf, r);
    chk_resp(r, RESP_OKAY, "write response");
    axi_write(ADDR_GATE12, 32'h00003c5a, 4'h3, r);
    chk_resp(r, RESP_OKAY, "write response");
    rd_chk(ADDR_GATE34, 32'h0000a5c3, RESP_OKAY);
    rd_chk(ADDR_GATE12, 32'h00003c5a, RESP_OKAY);
    axi_write(ADDR_GATE34, 32'h0000ffff, 4'h1, r);
    rd_chk(ADDR_GATE34, 32'h0000a5ff, RESP_OKAY);
    axi_write(14'h1000, 32'h0000ffff, 4'hf, r);
    chk_resp(r, RESP_SLVERR, "unmapped write");
    rd_chk(14'h1000, 32'h0, RESP_SLVERR);
    rd_chk(ADDR_GATE34 + 14'h2, 32'h0, RESP_SLVERR);
    $display("TB: register access done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(ADDR_GATE34, 32'h0, RESP_OKAY);
    rd_chk(ADDR_GATE12, 32'h0, RESP_OKAY);
    $display("TB: mid-run reset done");
    axi_write(ADDR_GATE12, 32'h0, 4'h3, r);
    axi_write(ADDR_GATE34, 32'h0, 4'h3, r);
    for (i = 0; i < 4; i++) src_in[i] <= 8'hff;
    repeat (2) @(posedge aclk);
    chk_sig(gate_out, 4'h0, "empty gates");
    axi_write(ADDR_POLARITY, 32'h5, 4'h1, r);
    repeat (2) @(posedge aclk);
    chk_sig(gate_out, 4'h5, "polarity");
    axi_write(ADDR_POLARITY, 32'h0, 4'h1, r);
    $display("TB: polarity done");
    for (k = 0; k < 8; k++) begin
      d = 32'h0;
      for (i = 0; i < 4; i++) d[i*4 +: 3] = k[2:0];
      axi_write(ADDR_SELECT, d, 4'h3, r);
      for (i = 0; i < 4; i++) src_in[i] <= i[0] ? (8'h01 << k) : ~(8'h01 << k);
      repeat (2) @(posedge aclk);
      chk_sig(source_data, 4'ha, "source select");
    end
    axi_write(ADDR_SELECT, 32'h0, 4'h3, r);
    $display("TB: source select done");
    for (g = 0; g < 4; g++) begin
      for (b = 0; b < 8; b++) begin
        d = 32'h0;
        d[(g % 2) * 8 + b] = 1'b1;
        axi_write(ADDR_GATE12, (g < 2) ? d : 32'h0, 4'h3, r);
        axi_write(ADDR_GATE34, (g >= 2) ? d : 32'h0, 4'h3, r);
        for (p = 0; p < 2; p++) begin
          for (i = 0; i < 4; i++) src_in[i] <= (i == b / 2 && p == 1) ? 8'hff : 8'h00;
          repeat (2) @(posedge aclk);
          e = 4'h0;
          e[g] = b[0] ? p[0] : !p[0];
          chk_sig(gate_out, e, "gate output");
          chk_sig(source_data, p[0] ? (4'h1 << (b / 2)) : 4'h0, "source data");
        end
      end
    end
    $display("TB: gate enables done");
    clk_en <= 1'b0;
    for (i = 0; i < 4; i++) src_in[i] <= 8'h00;
    repeat (2) @(posedge aclk);
    chk_sig(source_data, 4'h8, "frozen source");
    chk_sig(gate_out, 4'h8, "frozen gate");
    clk_en <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_sig(source_data, 4'h0, "resumed source");
    chk_sig(gate_out, 4'h0, "resumed gate");
    $display("TB: clock enable done");
    axi_write(ADDR_GATE34, 32'h00000081, 4'h3, r);
    for (p = 0; p < 4; p++) begin
      for (i = 0; i < 4; i++) src_in[i] <= ((i == 0 && p[0]) || (i == 3 && p[1])) ? 8'hff : 8'h00;
      repeat (2) @(posedge aclk);
      chk_sig(gate_out, {1'b0, p[1] | !p[0], 2'b00}, "gate 3 or");
    end
    $display("TB: gate or done");
    close_out();
  end
endmodule
